// [piexp_top.sv]
// Purpose: Peripheral interrupt expander onto six core interrupt lines
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: Table order below is overall priority order
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`default_nettype none
`include "pie_defines.svh"
module piexp_top #(
  parameter int NSRC = `PIEXP_NSRC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NSRC-1:0] irq_in,
  input wire logic [5:0] core_ack,
  input wire logic reset_request,
  output logic [5:0] core_lines,
  output logic nmi_request,
  output logic core_reset,
  output logic [15:0] peripheral_vector_code,
  output logic irq
);
  import piexp_pkg::*;
  localparam int IW = $clog2(NSRC);
  // Source table, in overall priority order; index = position, bit = group*16+bit
  localparam logic [5:0] SBIT [48] = '{
    6'd0,
    6'd32,
    6'd1,
    6'd2,
    6'd3,
    6'd4,
    6'd5,
    6'd6,
    6'd7,
    6'd8,
    6'd9,
    6'd10,
    6'd11,
    6'd12,
    6'd13,
    6'd14,
    6'd15,
    6'd33,
    6'd34,
    6'd35,
    6'd36,
    6'd37,
    6'd38,
    6'd39,
    6'd16,
    6'd17,
    6'd18,
    6'd19,
    6'd40,
    6'd41,
    6'd42,
    6'd43,
    6'd20,
    6'd21,
    6'd22,
    6'd44,
    6'd45,
    6'd46,
    6'd23,
    6'd24,
    6'd25,
    6'd26,
    6'd27,
    6'd28,
    6'd29,
    6'd30,
    6'd31,
    6'd47};
  localparam logic [15:0] SCODE [48] = '{
    16'h0020,
    16'h0019,
    16'h0004,
    16'h0001,
    16'h0011,
    16'h0005,
    16'h0006,
    16'h0007,
    16'h0040,
    16'h0041,
    16'h0021,
    16'h0022,
    16'h0023,
    16'h0027,
    16'h0028,
    16'h0029,
    16'h002a,
    16'h0024,
    16'h0025,
    16'h0026,
    16'h002f,
    16'h0030,
    16'h0031,
    16'h0032,
    16'h002b,
    16'h002c,
    16'h002d,
    16'h002e,
    16'h0039,
    16'h003a,
    16'h003b,
    16'h003c,
    16'h0033,
    16'h0034,
    16'h0035,
    16'h0036,
    16'h0037,
    16'h0038,
    16'h0005,
    16'h0006,
    16'h0007,
    16'h0040,
    16'h0041,
    16'h0004,
    16'h0001,
    16'h0011,
    16'h0000,
    16'h0000};
  localparam logic [2:0] SLINE [48] = '{
    3'd0, 3'd0, 3'd0, 3'd0, 3'd0, 3'd0, 3'd0, 3'd0, 3'd0, 3'd0, 3'd1, 3'd1, 3'd1,
    3'd1, 3'd1, 3'd1, 3'd1, 3'd1, 3'd1, 3'd1, 3'd1, 3'd1, 3'd1, 3'd1, 3'd2, 3'd2,
    3'd2, 3'd2, 3'd2, 3'd2, 3'd2, 3'd2, 3'd3, 3'd3, 3'd3, 3'd3, 3'd3, 3'd3, 3'd4,
    3'd4, 3'd4, 3'd4, 3'd4, 3'd5, 3'd5, 3'd5, 3'd6, 3'd6};
  // Index 46 and 47 are unused slots, parked on no line
  piexp_src_t pending_reg, pending_next, enable_reg, enable_next;
  piexp_lines_t core_mask_reg, core_mask_next;
  logic [15:0] acknowledge_reg, acknowledge_next;
  logic [5:0] stat_reg, stat_next, imsk_reg, imsk_next;
  logic nmi_reg, nmi_next;
  piexp_bus_t bus_reg, bus_next;
  logic [7:0] addr_reg, addr_next;
  logic wr_reg, wr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [NSRC-1:0] live;
  logic [5:0] any;
  logic [IW-1:0] idx [6];
  logic [15:0] code [6];
  logic [6*NSRC-1:0] req_flat;
  logic [6*NSRC*16-1:0] code_flat;

  always_comb begin
    req_flat = '0;
    code_flat = '0;
    for (int i = 0; i < NSRC; i++) begin
      live[i] = pending_reg[SBIT[i]] & enable_reg[SBIT[i]];
      for (int l = 0; l < 6; l++) begin
        req_flat[l*NSRC+i] = live[i] && (SLINE[i] == 3'(l));
        code_flat[(l*NSRC+i)*16 +: 16] = SCODE[i];
      end
    end
  end

  for (genvar g = 0; g < 6; g++) begin : g_line
    piexp_pick #(.N(NSRC)) u_pick (
      .req(req_flat[g*NSRC +: NSRC]),
      .codes(code_flat[g*NSRC*16 +: NSRC*16]),
      .any(any[g]),
      .idx(idx[g]),
      .code(code[g])
    );
  end

  assign core_lines = any & core_mask_reg;
  assign core_reset = reset_request | ~hresetn;
  assign nmi_request = nmi_reg;
  assign peripheral_vector_code = acknowledge_reg;
  assign irq = |(stat_reg & imsk_reg);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  always_comb begin
    logic take;
    logic [31:0] w;
    take = 1'b0;
    w = '0;
    pending_next = pending_reg;
    enable_next = enable_reg;
    core_mask_next = core_mask_reg;
    acknowledge_next = acknowledge_reg;
    stat_next = stat_reg;
    imsk_next = imsk_reg;
    nmi_next = 1'b0;
    bus_next = PIEXP_IDLE;
    addr_next = addr_reg;
    wr_next = 1'b0;
    rdata_next = rdata_reg;
    take = hsel && hready && htrans[1];
    if (take) begin
      bus_next = PIEXP_DATA;
      addr_next = haddr[7:0];
      wr_next = hwrite;
    end
    // Pending clears by acknowledge first; new events then set, so set wins
    for (int l = 0; l < 6; l++) begin
      if (core_ack[l]) begin
        acknowledge_next = any[l] ? code[l] : `PIEXP_PHANTOM;
        if (any[l]) begin
          pending_next[SBIT[idx[l]]] = 1'b0;
        end
      end
    end
    if (bus_reg == PIEXP_DATA) begin
      w = hwdata;
      if (wr_reg) begin
        case (addr_reg)
          `PIEXP_OFF_PEND0: pending_next[15:0] = pending_next[15:0] & ~w[15:0];
          `PIEXP_OFF_PEND1: pending_next[31:16] = pending_next[31:16] & ~w[15:0];
          `PIEXP_OFF_PEND2: pending_next[47:32] = pending_next[47:32] & ~w[15:0];
          `PIEXP_OFF_ENA0: enable_next[15:0] = w[15:0];
          `PIEXP_OFF_ENA1: enable_next[31:16] = w[15:0];
          `PIEXP_OFF_ENA2: enable_next[47:32] = w[15:0];
          `PIEXP_OFF_MASK: core_mask_next = w[5:0];
          `PIEXP_OFF_IMSK: imsk_next = w[5:0];
          `PIEXP_OFF_NMI: nmi_next = w[0];
          default: ;
        endcase
      end else begin
        case (addr_reg)
          `PIEXP_OFF_STAT: stat_next = '0;
          default: ;
        endcase
      end
    end
    pending_next = pending_next | irq_in;
    stat_next = stat_next | core_lines;
    // Read data formed in the address phase so it stands in the data phase
    if (take && !hwrite) begin
      case (haddr[7:0])
        `PIEXP_OFF_PEND0: rdata_next = {16'h0000, pending_reg[15:0]};
        `PIEXP_OFF_PEND1: rdata_next = {16'h0000, pending_reg[31:16]};
        `PIEXP_OFF_PEND2: rdata_next = {16'h0000, pending_reg[47:32]};
        `PIEXP_OFF_ENA0: rdata_next = {16'h0000, enable_reg[15:0]};
        `PIEXP_OFF_ENA1: rdata_next = {16'h0000, enable_reg[31:16]};
        `PIEXP_OFF_ENA2: rdata_next = {16'h0000, enable_reg[47:32]};
        `PIEXP_OFF_MASK: rdata_next = {26'h0, core_mask_reg};
        `PIEXP_OFF_VEC: rdata_next = {16'h0000, acknowledge_reg};
        `PIEXP_OFF_LINES: rdata_next = {26'h0, core_lines};
        `PIEXP_OFF_STAT: rdata_next = {26'h0, stat_reg};
        `PIEXP_OFF_IMSK: rdata_next = {26'h0, imsk_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending_reg <= '0;
      enable_reg <= '0;
      core_mask_reg <= '0;
      acknowledge_reg <= `PIEXP_RESET_VEC;
      stat_reg <= '0;
      imsk_reg <= '0;
      nmi_reg <= 1'b0;
      bus_reg <= PIEXP_IDLE;
      addr_reg <= '0;
      wr_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      pending_reg <= pending_next;
      enable_reg <= enable_next;
      core_mask_reg <= core_mask_next;
      acknowledge_reg <= acknowledge_next;
      stat_reg <= stat_next;
      imsk_reg <= imsk_next;
      nmi_reg <= nmi_next;
      bus_reg <= bus_next;
      addr_reg <= addr_next;
      wr_reg <= wr_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule
`default_nettype wire

// [pie_defines.svh]
// Purpose: Constants for the peripheral interrupt expander
// Assumes: 32-bit AHB-Lite register words
// Notes: Offsets are byte addresses
`ifndef PIE_DEFINES_SVH
`define PIE_DEFINES_SVH
`define PIEXP_NSRC 48
`define PIEXP_OFF_PEND0 8'h00
`define PIEXP_OFF_PEND1 8'h04
`define PIEXP_OFF_PEND2 8'h08
`define PIEXP_OFF_ENA0 8'h0c
`define PIEXP_OFF_ENA1 8'h10
`define PIEXP_OFF_ENA2 8'h14
`define PIEXP_OFF_MASK 8'h18
`define PIEXP_OFF_VEC 8'h1c
`define PIEXP_OFF_LINES 8'h20
`define PIEXP_OFF_STAT 8'h24
`define PIEXP_OFF_IMSK 8'h28
`define PIEXP_OFF_NMI 8'h2c
`define PIEXP_RESET_VEC 16'h0000
`define PIEXP_NMI_VEC 16'h0024
`define PIEXP_LINE1_VEC 16'h0002
`define PIEXP_LINE2_VEC 16'h0004
`define PIEXP_PHANTOM 16'h0000
`define PIEXP_RESET_PRIO 6'd1
`define PIEXP_NMI_PRIO 6'd3
`endif

// [piexp_pkg.sv]
// Purpose: Types for the peripheral interrupt expander
// Assumes: Used with pie_defines.svh
// Notes: Six core lines
`default_nettype none
package piexp_pkg;
  typedef logic [5:0] piexp_lines_t;
  typedef logic [15:0] piexp_vec_t;
  typedef logic [47:0] piexp_src_t;
  typedef enum logic [1:0] {
    PIEXP_IDLE = 2'b00,
    PIEXP_DATA = 2'b01
  } piexp_bus_t;
endpackage
`default_nettype wire

// [piexp_pick.sv]
// Purpose: Picks the highest priority pending source of one core line
// Assumes: Caller lists sources in priority order, lowest index wins
// Notes: One instance per core line
`default_nettype none
`include "pie_defines.svh"
module piexp_pick #(
  parameter int N = 48
) (
  input wire logic [N-1:0] req,
  input wire logic [N*16-1:0] codes,
  output logic any,
  output logic [$clog2(N)-1:0] idx,
  output logic [15:0] code
);
  always_comb begin
    any = 1'b0;
    idx = '0;
    code = `PIEXP_PHANTOM;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = i[$clog2(N)-1:0];
        code = codes[i*16 +: 16];
      end
    end
  end
endmodule
`default_nettype wire

// [piexp_checker.sv]
// Purpose: Port checks for the interrupt expander
// Assumes: Sees top module ports only
// Notes: Bound to piexp_top
`default_nettype none
module piexp_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [5:0] core_ack,
  input wire logic reset_request,
  input wire logic [5:0] core_lines,
  input wire logic nmi_request,
  input wire logic core_reset,
  input wire logic [15:0] peripheral_vector_code,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic nmi_wr;
  logic bus_wr;
  assign bus_wr = hsel && htrans[1] && hwrite;
  assign nmi_wr = bus_wr && (haddr[7:0] == 8'h2c);
  a_reset_follows_pin: assert property (core_reset == reset_request)
    else $error("core reset differs from request");
  a_nmi_from_write: assert property (nmi_request |-> $past(nmi_wr, 2) || $past(nmi_wr, 3))
    else $error("nmi without software write");
  // A back-to-back second trigger legally makes the pulse two cycles long
  a_nmi_one_pulse: assert property (nmi_request && !$past(nmi_wr) |=> !nmi_request)
    else $error("nmi longer than one cycle");
  a_ack_gives_code: assert property ((core_ack & core_lines) != 6'h00 |=>
    peripheral_vector_code != 16'h0000) else $error("ack left phantom code");
  a_code_holds: assert property (core_ack == 6'h00 |=> $stable(peripheral_vector_code))
    else $error("code changed without ack");
  a_line_one_code: assert property (core_ack[0] && core_lines[0] |=>
    peripheral_vector_code inside {16'h0020, 16'h0019, 16'h0004, 16'h0001, 16'h0011,
    16'h0005, 16'h0006, 16'h0007, 16'h0040, 16'h0041}) else $error("bad line one code");
  a_line_two_code: assert property (core_ack[1] && core_lines[1] |=>
    peripheral_vector_code inside {[16'h0021:16'h002a], [16'h002f:16'h0032]})
    else $error("bad line two code");
  a_irq_has_cause: assert property ($rose(irq) |-> $past(|core_lines) || $past(bus_wr, 2))
    else $error("irq without cause");
  cover property (|core_ack);
  cover property (nmi_request);
  cover property ($rose(irq));
endmodule
bind piexp_top piexp_checker i_piexp_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .core_ack(core_ack),
  .reset_request(reset_request), .core_lines(core_lines), .nmi_request(nmi_request),
  .core_reset(core_reset), .peripheral_vector_code(peripheral_vector_code), .irq(irq));
`default_nettype wire

// [piexp_cpu_model.sv]
// Purpose: Core side that acknowledges raised lines
// Assumes: Lowest raised line is taken first
// Notes: dly sets how slowly it answers
`default_nettype none
module piexp_cpu_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [5:0] core_lines,
  input wire logic ack_en,
  input wire logic [3:0] dly,
  output logic [5:0] core_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  // One-cycle ack, then a gap so one request is never taken twice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
      core_ack <= 6'h00;
    end else if (ack_en && (|core_lines) && core_ack == 6'h00) begin
      if (cnt >= dly) begin
        core_ack <= core_lines & (~core_lines + 6'h01);
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      core_ack <= 6'h00;
      cnt <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// [tb_piexp_top.sv]
// Purpose: Self-checking bench for the interrupt expander
// Assumes: Zero wait AHB-Lite slave
// Notes: Core side is a behavioural model
`default_nettype none
`include "pie_defines.svh"
module tb_piexp_top;
  timeunit 1ns;
  timeprecision 1ns;
  import piexp_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, reset_request = 0, ack_en = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [47:0] irq_in = 0;
  logic [3:0] dly = 0;
  logic hreadyout, hresp, nmi_request, core_reset, irq;
  logic [5:0] core_ack, core_lines;
  piexp_vec_t peripheral_vector_code;
  int err_count = 0, comparisons = 0, cyc = 0, nmi_cnt = 0;
  localparam int bits[16] = '{1, 2, 3, 4, 5, 6, 7, 8, 12, 13, 14, 15, 36, 37, 38, 39};
  localparam piexp_vec_t codes[16] = '{16'h0004, 16'h0001, 16'h0011, 16'h0005, 16'h0006,
    16'h0007, 16'h0040, 16'h0041, 16'h0027, 16'h0028, 16'h0029, 16'h002a, 16'h002f,
    16'h0030, 16'h0031, 16'h0032};
  always #25 hclk = ~hclk;
  piexp_top i_piexp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_in(irq_in),
    .core_ack(core_ack), .reset_request(reset_request), .core_lines(core_lines),
    .nmi_request(nmi_request), .core_reset(core_reset),
    .peripheral_vector_code(peripheral_vector_code), .irq(irq));
  piexp_cpu_model i_piexp_cpu_model (.hclk(hclk), .hresetn(hresetn), .core_lines(core_lines),
    .ack_en(ack_en), .dly(dly), .core_ack(core_ack));
  always @(posedge hclk) begin
    cyc++;
    nmi_cnt += int'(nmi_request === 1'b1);
    if (cyc == 4000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (err_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    #1;
  endtask
  task pulse(input int b);
    irq_in[b] <= 1'b1;
    @(posedge hclk);
    irq_in[b] <= 1'b0;
    #1;
  endtask
  // Bounded so a missing ack shows up as a wrong code, not a hang
  task automatic wait_ack;
    for (int i = 0; i < 20; i++) begin
      @(posedge hclk);
      if (core_ack !== 6'h00) break;
    end
    #1;
  endtask
  task t_reset;
    chk(core_reset, 1);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk(core_reset, 0);
    chk({hreadyout, hresp}, 2'b10);
    chk(peripheral_vector_code, `PIEXP_PHANTOM);
    reset_request <= 1'b1;
    #1;
    chk(core_reset, 1);
    reset_request <= 1'b0;
  endtask
  task t_table;
    bus(`PIEXP_OFF_ENA0, 1, 32'hffff);
    bus(`PIEXP_OFF_ENA2, 1, 32'hffff);
    bus(`PIEXP_OFF_MASK, 1, 32'h3f);
    dly <= 4'h3;
    ack_en <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      pulse(bits[i]);
      chk(core_lines, bits[i] > 8 ? 32'h2 : 32'h1);
      wait_ack();
      chk(peripheral_vector_code, codes[i]);
      chk(core_lines, 0);
    end
  endtask
  task t_priority;
    ack_en <= 1'b0;
    irq_in <= 48'h0080_0000_d000;
    @(posedge hclk);
    irq_in <= 48'h0;
    dly <= 4'h0;
    ack_en <= 1'b1;
    wait_ack();
    chk(peripheral_vector_code, 16'h0027);
    wait_ack();
    chk(peripheral_vector_code, 16'h0029);
    wait_ack();
    chk(peripheral_vector_code, 16'h002a);
    wait_ack();
    chk(peripheral_vector_code, 16'h0032);
  endtask
  task t_gating;
    ack_en <= 1'b0;
    bus(`PIEXP_OFF_MASK, 1, 32'h3e);
    pulse(1);
    chk(core_lines[0], 0);
    bus(`PIEXP_OFF_MASK, 1, 32'h3f);
    chk(core_lines[0], 1);
    bus(`PIEXP_OFF_ENA0, 1, 32'h0);
    chk(core_lines[0], 0);
    bus(`PIEXP_OFF_ENA0, 1, 32'hffff);
    ack_en <= 1'b1;
    wait_ack();
    chk(peripheral_vector_code, 16'h0004);
  endtask
  task t_intr;
    ack_en <= 1'b0;
    bus(`PIEXP_OFF_IMSK, 1, 32'h0);
    pulse(2);
    @(posedge hclk);
    #1;
    chk(irq, 0);
    bus(`PIEXP_OFF_IMSK, 1, 32'h3f);
    @(posedge hclk);
    #1;
    chk(irq, 1);
    bus(`PIEXP_OFF_STAT, 0, 32'h0);
    chk(rd[0], 1);
    bus(`PIEXP_OFF_PEND0, 1, 32'h4);
    bus(`PIEXP_OFF_STAT, 0, 32'h0);
    @(posedge hclk);
    #1;
    chk(irq, 0);
    bus(32'h40, 0, 32'h0);
    chk(rd, 0);
  endtask
  task automatic t_nmi;
    int n0;
    n0 = nmi_cnt;
    bus(`PIEXP_OFF_NMI, 1, 32'h1);
    repeat (3) @(posedge hclk);
    #1;
    chk(nmi_cnt - n0, 1);
  endtask
  initial begin
    #1;
    t_reset();
    t_table();
    t_priority();
    t_gating();
    t_intr();
    t_nmi();
    final_report();
  end
endmodule
`default_nettype wire
